// ==== isw_defs.svh ====
// Purpose: constants for the isa slave strobe and width decode block
// Assumes: 50 MHz ref_clk, bus strobes active low and asynchronous
// Notes: window base and decode settings are plain defaults
// Operation
// R1 - In 16-bit shared memory mode the wide memory ack is asserted for any address inside the 128 kbyte region holding the window.
// R2 - In I/O mode a 16-bit port access answered by the device asserts the wide I/O ack and drives all sixteen data lines; code drives them on reads only.
// R3 - Memory accesses use the full strobes in 16-bit mode and the low-meg strobes when the width strap is low.
// R4 - The host pulses the low-meg strobes only for accesses inside the lowest 1 Megabyte.
// R5 - Boot PROM accesses are qualified by the low-meg strobes.
// R6 - The host raises the byte-high enable whenever it expects the upper byte lane to carry data; code reads a low byte_high_en_n as upper-byte data.
// R7 - Port writes use the port write strobe and port reads the port read strobe, and the device answers each.
// R8 - Bus reset returns the device to its reset state while asserted.
// R9 - Wait-state correction in 16-bit I/O mode watches the full memory strobes.
// R10 - A high width strap selects 16-bit mode and a low one 8-bit mode, default low.
// R11 - The ready output inserts wait states into accesses not yet complete.
// R12 - The open-collector wide acks are driven low only while asserted and released otherwise.
`ifndef ISW_DEFS_SVH
`define ISW_DEFS_SVH
`define ISW_REGION_SHIFT   17
`define ISW_REGION_W       7
`define ISW_MEM_BASE_RST   7'h06
`define ISW_PROM_BASE_RST  20'hC8000
`define ISW_PROM_SIZE_SH   14
`define ISW_IO_BASE_RST    10'h300
`define ISW_IO_SIZE_SH     5
`define ISW_WAIT_NS        200
`define ISW_CLK_NS         20
`define ISW_WAIT_CYC       ((`ISW_WAIT_NS + `ISW_CLK_NS - 1) / `ISW_CLK_NS)
`define ISW_CNT_W          4
`endif

// ==== isw_pkg.sv ====
// Purpose: shared types for the strobe and width decode block
// Assumes: nothing beyond the defs header
// Notes: types only
package isw_pkg;
  typedef enum logic [1:0] {
    ISW_IDLE = 2'b00,
    ISW_WAIT = 2'b01,
    ISW_DONE = 2'b10
  } isw_state_e;
  typedef logic [3:0] isw_cnt_t;
endpackage

// ==== isw_sync_if.sv ====
// Purpose: carries synchronised bus strobes between sync and decode logic
// Assumes: single clock domain
// Notes: all strobes active low
interface isw_sync_if;
  logic mem_rd_n;
  logic mem_wr_n;
  logic low_rd_n;
  logic low_wr_n;
  logic port_rd_n;
  logic port_wr_n;
  logic wide_strap;
  modport src (output mem_rd_n, mem_wr_n, low_rd_n, low_wr_n,
               output port_rd_n, port_wr_n, wide_strap);
  modport dst (input mem_rd_n, mem_wr_n, low_rd_n, low_wr_n,
               input port_rd_n, port_wr_n, wide_strap);
endinterface

// ==== isw_sync.sv ====
// Purpose: two-stage synchroniser for the asynchronous bus strobes
// Assumes: rst synchronous active high
// Notes: first stage feeds only the second stage
module isw_sync (
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst,
  // raw pins
  input  wire logic   mem_read_strobe_n,
  input  wire logic   mem_write_strobe_n,
  input  wire logic   lowmeg_read_strobe_n,
  input  wire logic   lowmeg_write_strobe_n,
  input  wire logic   port_read_strobe_n,
  input  wire logic   port_write_strobe_n,
  input  wire logic   bus_width_strap,
  // synchronised side
  isw_sync_if.src     so
);
  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
  } isw_sync_s;
  isw_sync_s st;
  isw_sync_s next_st;
  always_comb begin
    next_st    = st;
    next_st.s1 = {mem_read_strobe_n, mem_write_strobe_n,
                  lowmeg_read_strobe_n, lowmeg_write_strobe_n,
                  port_read_strobe_n, port_write_strobe_n, bus_width_strap};
    next_st.s2 = st.s1;
  end
  // strobes idle high, strap idle low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= {7'h7E, 7'h7E};
    end else begin
      st <= next_st;
    end
  end
  assign so.mem_rd_n   = st.s2[6];
  assign so.mem_wr_n   = st.s2[5];
  assign so.low_rd_n   = st.s2[4];
  assign so.low_wr_n   = st.s2[3];
  assign so.port_rd_n  = st.s2[2];
  assign so.port_wr_n  = st.s2[1];
  assign so.wide_strap = st.s2[0];
endmodule // isw_sync

// ==== isw_decode.sv ====
// Purpose: isa slave strobe selection, width decode and wide-cycle acks
// Assumes: address lines stable while strobes are low; host keeps R4, R6
// Notes: acks are open collector, oe high means pin pulled low
`include "isw_defs.svh"
module isw_decode
  import isw_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // isa address and control
  input  wire logic [23:0] bus_addr,
  input  wire logic        byte_high_en_n,
  input  wire logic        mem_read_strobe_n,
  input  wire logic        mem_write_strobe_n,
  input  wire logic        lowmeg_read_strobe_n,
  input  wire logic        lowmeg_write_strobe_n,
  input  wire logic        port_read_strobe_n,
  input  wire logic        port_write_strobe_n,
  input  wire logic        bus_width_strap,
  // mode selection from configuration logic
  input  wire logic        shared_mem_mode,
  input  wire logic        access_done,
  // open-collector acks and ready
  output logic             wide_mem_cycle_ack_o,
  output logic             wide_mem_cycle_ack_oe,
  output logic             wide_io_cycle_ack_o,
  output logic             wide_io_cycle_ack_oe,
  output logic             wait_insert_ready_o,
  output logic             wait_insert_ready_oe,
  // qualified strobes to the core
  output logic             mem_rd_sel,
  output logic             mem_wr_sel,
  output logic             prom_rd_sel,
  output logic             port_rd_sel,
  output logic             port_wr_sel,
  output logic             drive_high_byte,
  output logic             drive_all_lanes,
  output logic             wide_mode
);
  isw_sync_if sy ();
  isw_sync u_sync (
    .ref_clk               (ref_clk),
    .rst                   (rst),
    .mem_read_strobe_n     (mem_read_strobe_n),
    .mem_write_strobe_n    (mem_write_strobe_n),
    .lowmeg_read_strobe_n  (lowmeg_read_strobe_n),
    .lowmeg_write_strobe_n (lowmeg_write_strobe_n),
    .port_read_strobe_n    (port_read_strobe_n),
    .port_write_strobe_n   (port_write_strobe_n),
    .bus_width_strap       (bus_width_strap),
    .so                    (sy)
  );

  typedef struct packed {
    logic        mem_ack;
    logic        io_ack;
    logic        rdy_hold;
    logic        mem_rd;
    logic        mem_wr;
    logic        prom_rd;
    logic        port_rd;
    logic        port_wr;
    logic        hi_byte;
    logic        all_lanes;
    logic        wide;
    isw_state_e  state;
    isw_cnt_t    cnt;
    // pin stages sit beside the strobe stages so all arrive together
    logic [23:0] addr_s1;
    logic [23:0] addr_s2;
    logic        bhe_s1;
    logic        bhe_s2;
    logic        ctl_s1;
    logic        ctl_s2;
  } isw_dec_s;

  isw_dec_s st;
  isw_dec_s next_st;

  // second pin stage, named for the decode below
  logic [23:0] addr_s2;
  logic        bhe_s2;
  logic        mem_ctl_s2;
  logic        done_d;

  assign addr_s2    = st.addr_s2;
  assign bhe_s2     = st.bhe_s2;
  assign mem_ctl_s2 = st.ctl_s2;
  // core handshake already runs on ref_clk, so it skips the flops
  assign done_d     = access_done;

  logic in_region;
  logic in_prom;
  logic in_ports;
  logic mem_rd_q;
  logic mem_wr_q;
  logic low_rd_q;
  logic low_wr_q;
  logic any_access;
  logic wide_io_req;
  logic port_access;
  logic prom_access;
  logic region_access;
  logic wait_expired;
  logic io_fix_release;

  always_comb begin
    in_region = addr_s2[23:`ISW_REGION_SHIFT] == `ISW_MEM_BASE_RST; // [R1]
    in_prom   = addr_s2[19:`ISW_PROM_SIZE_SH] ==
                `ISW_PROM_BASE_RST >> `ISW_PROM_SIZE_SH;
    in_ports  = addr_s2[9:`ISW_IO_SIZE_SH] ==
                `ISW_IO_BASE_RST >> `ISW_IO_SIZE_SH;
    mem_rd_q  = !sy.mem_rd_n;
    mem_wr_q  = !sy.mem_wr_n;
    low_rd_q  = !sy.low_rd_n;
    low_wr_q  = !sy.low_wr_n;
    port_access   = in_ports && (!sy.port_rd_n || !sy.port_wr_n);
    prom_access   = in_prom && low_rd_q;
    region_access = in_region &&
                    (mem_rd_q || mem_wr_q || low_rd_q || low_wr_q);
    any_access    = port_access || prom_access || region_access;
    wide_io_req   = sy.wide_strap && !bhe_s2 && port_access;       // [R2]
    // the hold gives up after a fixed count even if the core stalls
    wait_expired  = st.cnt == isw_cnt_t'(`ISW_WAIT_CYC);           // [R11]
    // in 16-bit port mode a memory strobe means the host has moved on,
    // so ready must not stay low
    io_fix_release = sy.wide_strap && !mem_ctl_s2 &&
                     (mem_rd_q || mem_wr_q);                        // [R9]
  end

  always_comb begin
    next_st           = st;
    next_st.addr_s1   = bus_addr;
    next_st.addr_s2   = st.addr_s1;
    next_st.bhe_s1    = byte_high_en_n;
    next_st.bhe_s2    = st.bhe_s1;
    next_st.ctl_s1    = shared_mem_mode;
    next_st.ctl_s2    = st.ctl_s1;
    next_st.wide      = sy.wide_strap;                               // [R10]
    next_st.mem_ack   = mem_ctl_s2 && sy.wide_strap && in_region;     // [R1]
    next_st.io_ack    = !mem_ctl_s2 && wide_io_req;                  // [R2]
    next_st.all_lanes = !mem_ctl_s2 && wide_io_req && !sy.port_rd_n; // [R2]
    next_st.hi_byte   = sy.wide_strap && !bhe_s2;                    // [R6]
    if (sy.wide_strap) begin
      next_st.mem_rd = mem_ctl_s2 && in_region && mem_rd_q;          // [R3]
      next_st.mem_wr = mem_ctl_s2 && in_region && mem_wr_q;          // [R3]
    end else begin
      next_st.mem_rd = mem_ctl_s2 && in_region && low_rd_q;          // [R3]
      next_st.mem_wr = mem_ctl_s2 && in_region && low_wr_q;          // [R3]
    end
    next_st.prom_rd = in_prom && low_rd_q;                            // [R5]
    next_st.port_rd = in_ports && !sy.port_rd_n;                      // [R7]
    next_st.port_wr = in_ports && !sy.port_wr_n;                      // [R7]
    case (st.state)
      ISW_IDLE: begin
        next_st.cnt = '0;
        if (any_access && !done_d) begin
          next_st.state    = ISW_WAIT;
          next_st.rdy_hold = 1'b1;                                    // [R11]
        end
      end
      ISW_WAIT: begin
        next_st.cnt = st.cnt + 4'h1;
        if (done_d || wait_expired || io_fix_release) begin
          next_st.state    = ISW_DONE;                                // [R9]
          next_st.rdy_hold = 1'b0;                                    // [R11]
        end
      end
      ISW_DONE: begin
        // wait for the strobes to rise so one access holds only once
        if (!any_access) begin
          next_st.state = ISW_IDLE;
        end
      end
      default: begin
        next_st.state    = ISW_IDLE;
        next_st.rdy_hold = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin                                                    // [R8]
      // byte-high stages idle high like the strobes, all else low
      st <= '{mem_ack:   1'b0,
              io_ack:    1'b0,
              rdy_hold:  1'b0,
              mem_rd:    1'b0,
              mem_wr:    1'b0,
              prom_rd:   1'b0,
              port_rd:   1'b0,
              port_wr:   1'b0,
              hi_byte:   1'b0,
              all_lanes: 1'b0,
              wide:      1'b0,
              state:     ISW_IDLE,
              cnt:       4'h0,
              addr_s1:   24'h000000,
              addr_s2:   24'h000000,
              bhe_s1:    1'b1,
              bhe_s2:    1'b1,
              ctl_s1:    1'b0,
              ctl_s2:    1'b0};
    end else begin
      st <= next_st;
    end
  end

  // open collector: output level is always low, oe pulls the line
  assign wide_mem_cycle_ack_o  = 1'b0;
  assign wide_mem_cycle_ack_oe = st.mem_ack;                          // [R12]
  assign wide_io_cycle_ack_o   = 1'b0;
  assign wide_io_cycle_ack_oe  = st.io_ack;                           // [R12]
  assign wait_insert_ready_o   = 1'b0;
  assign wait_insert_ready_oe  = st.rdy_hold;                         // [R11]
  assign mem_rd_sel            = st.mem_rd;
  assign mem_wr_sel            = st.mem_wr;
  assign prom_rd_sel           = st.prom_rd;
  assign port_rd_sel           = st.port_rd;
  assign port_wr_sel           = st.port_wr;
  assign drive_high_byte       = st.hi_byte;
  assign drive_all_lanes       = st.all_lanes;
  assign wide_mode             = st.wide;
endmodule // isw_decode

// ==== isw_decode_asserts.sv ====
// Purpose: port checks for the strobe and width decode block
// Assumes: 3-edge pin to output latency, rst synchronous
// Notes: only the ports that the checks need are watched
module isw_decode_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // bus pins
  input wire logic [23:0] bus_addr,
  input wire logic        mem_read_strobe_n,
  input wire logic        lowmeg_read_strobe_n,
  input wire logic        port_read_strobe_n,
  input wire logic        bus_width_strap,
  input wire logic        shared_mem_mode,
  // outputs
  input wire logic        wide_mem_cycle_ack_o,
  input wire logic        wide_mem_cycle_ack_oe,
  input wire logic        wide_io_cycle_ack_o,
  input wire logic        wide_io_cycle_ack_oe,
  input wire logic        wait_insert_ready_oe,
  input wire logic        mem_rd_sel,
  input wire logic        prom_rd_sel,
  input wire logic        port_rd_sel,
  input wire logic        drive_all_lanes,
  input wire logic        wide_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAIT_MAX = 12;
  logic [4:0] wcnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // consecutive cycles of wait held, to bound it without a long repeat
  always_ff @(posedge ref_clk) begin
    wcnt <= (rst || !wait_insert_ready_oe) ? 5'h00 : wcnt + 5'h01;
  end
  // sync stages have flushed reset values after four free edges
  sequence s_out_of_reset;
    !rst [*4];
  endsequence
  a_reset_clears: assert property ($fell(rst) |-> !(wide_mem_cycle_ack_oe
    || wide_io_cycle_ack_oe || wait_insert_ready_oe || mem_rd_sel
    || port_rd_sel || wide_mode)) else $error("outputs set after reset");
  a_oc_low_only: assert property (!wide_mem_cycle_ack_o
    && !wide_io_cycle_ack_o) else $error("ack driven high");
  a_width_copy: assert property (s_out_of_reset |->
    wide_mode == $past(bus_width_strap, 3)) else $error("width mode off");
  a_mem_region: assert property (s_out_of_reset |->
    wide_mem_cycle_ack_oe == $past(bus_width_strap && shared_mem_mode
    && bus_addr[23:17] == 7'h06, 3)) else $error("mem ack decode off");
  a_narrow_no_ack: assert property (!wide_mode |->
    !wide_mem_cycle_ack_oe && !wide_io_cycle_ack_oe)
    else $error("ack in 8-bit mode");
  a_strobe_choice: assert property (s_out_of_reset ##0 mem_rd_sel |->
    !$past(bus_width_strap ? mem_read_strobe_n : lowmeg_read_strobe_n, 3))
    else $error("wrong memory strobe used");
  a_prom_lowmeg: assert property (s_out_of_reset ##0 prom_rd_sel |->
    !$past(lowmeg_read_strobe_n, 3)) else $error("prom without strobe");
  a_port_read: assert property (s_out_of_reset ##0 port_rd_sel |->
    !$past(port_read_strobe_n, 3)) else $error("port read without strobe");
  a_all_lanes: assert property (drive_all_lanes |->
    wide_io_cycle_ack_oe && wide_mode) else $error("lanes without io ack");
  a_wait_bounded: assert property (wait_insert_ready_oe |->
    wcnt < WAIT_MAX) else $error("wait held too long");
endmodule // isw_decode_asserts

// ==== isw_host_model.sv ====
// Purpose: host bus master model driving strobes and bus reset
// Assumes: bench calls the tasks; pins change at falling edges
// Notes: strb_n bits mem rd, mem wr, low rd, low wr, port rd, port wr
module isw_host_model (
  // clock
  input wire logic ref_clk,
  // bus pins
  output logic        rst,
  output logic [23:0] bus_addr,
  output logic        byte_high_en_n,
  output logic [5:0]  strb_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rst = 1'b1;
    bus_addr = 24'h000000;
    byte_high_en_n = 1'b1;
    strb_n = 6'h3F;
  end
  task automatic bus_reset(input int n);
    @(negedge ref_clk) rst = 1'b1;
    repeat (n) @(negedge ref_clk);
    rst = 1'b0;
  endtask
  // k 0 mem rd, 1 mem wr, 2 port rd, 3 port wr; fl, lo pick strobes
  task automatic start(input logic [1:0] k, input logic fl, lo,
                       input logic [23:0] a, input logic w16);
    @(negedge ref_clk);
    bus_addr = a;
    byte_high_en_n = ~w16;
    if (k[1]) strb_n[4 + k[0]] = 1'b0;
    else begin
      strb_n[k[0]] = ~fl;
      strb_n[2 + k[0]] = ~(lo && a < 24'h100000);
    end
  endtask
  // released address shows the inverse, never the last value
  task automatic stop();
    @(negedge ref_clk);
    strb_n = 6'h3F;
    byte_high_en_n = 1'b1;
    bus_addr = ~bus_addr;
  endtask
endmodule // isw_host_model

// ==== test_isa_slave_strobe_width_decode.sv ====
// Purpose: self-checking bench for the strobe and width decode block
// Assumes: host model drives bus pins and reset, bench drives modes
// Notes: got bits mrd mwr prom prd pwr mack ioack hib all
module test_isa_slave_strobe_width_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import isw_pkg::*;
  typedef struct packed {
    logic [1:0] k; logic fl, lo; logic [23:0] a;
    logic st, sh, w; logic [8:0] e;
  } isw_row_s;
  isw_row_s rows [10] = '{'{0,1,1,24'hC0010,1,1,1,9'h10A},
    '{1,0,1,24'hDFFFE,0,1,0,9'h080}, '{0,0,1,24'hC0000,1,1,1,9'h00A},
    '{0,1,0,24'hC0000,0,1,0,9'h000}, '{0,1,1,24'hE0000,1,1,0,9'h000},
    '{0,1,1,24'hC8000,0,0,0,9'h040}, '{2,0,0,24'h000300,1,0,1,9'h027},
    '{3,0,0,24'h00031F,0,0,0,9'h010}, '{2,0,0,24'h000320,1,0,0,9'h000},
    '{2,0,0,24'h000300,0,0,0,9'h020}};
  logic ref_clk = 1'b0;
  logic strap = 1'b0, shared = 1'b0, done = 1'b1;
  logic rst, bhe_n;
  logic [23:0] bus_addr;
  logic [5:0] strb_n;
  wire [8:0] got;
  wire [2:0] oc;
  wire w_oe, wm;
  int n_fail = 0, n_tests = 0, cyc = 0;
  always #10 ref_clk = ~ref_clk;
  isw_host_model host (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
    .byte_high_en_n(bhe_n), .strb_n(strb_n));
  isw_decode dut (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
    .byte_high_en_n(bhe_n), .mem_read_strobe_n(strb_n[0]),
    .mem_write_strobe_n(strb_n[1]), .lowmeg_read_strobe_n(strb_n[2]),
    .lowmeg_write_strobe_n(strb_n[3]), .port_read_strobe_n(strb_n[4]),
    .port_write_strobe_n(strb_n[5]), .bus_width_strap(strap),
    .shared_mem_mode(shared), .access_done(done),
    .wide_mem_cycle_ack_o(oc[0]), .wide_mem_cycle_ack_oe(got[3]),
    .wide_io_cycle_ack_o(oc[1]), .wide_io_cycle_ack_oe(got[2]),
    .wait_insert_ready_o(oc[2]), .wait_insert_ready_oe(w_oe),
    .mem_rd_sel(got[8]), .mem_wr_sel(got[7]), .prom_rd_sel(got[6]),
    .port_rd_sel(got[5]), .port_wr_sel(got[4]),
    .drive_high_byte(got[1]), .drive_all_lanes(got[0]), .wide_mode(wm));
  task automatic chk(input logic [8:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // port read in 16-bit i/o mode, held so the wait is visible
  task automatic port_hold();
    @(negedge ref_clk) {strap, shared} = 2'b10;
    repeat (4) @(negedge ref_clk);
    host.start(2, 0, 0, 24'h000300, 1);
    repeat (4) @(negedge ref_clk);
    chk(w_oe, 1);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    host.bus_reset(5);
    chk(got, 9'h000);
    chk({oc, w_oe, wm}, 9'h000);
    $display("start reset test done");
    foreach (rows[i]) begin
      @(negedge ref_clk) {strap, shared} = {rows[i].st, rows[i].sh};
      repeat (4) @(negedge ref_clk);
      host.start(rows[i].k, rows[i].fl, rows[i].lo, rows[i].a, rows[i].w);
      repeat (4) @(negedge ref_clk);
      chk(got, rows[i].e);
      host.stop();
      repeat (14) @(negedge ref_clk);
      $display("row %0d done", i);
    end
    done = 1'b0;
    port_hold();
    repeat (14) @(negedge ref_clk);
    chk(w_oe, 0);
    host.stop();
    repeat (8) @(negedge ref_clk);
    port_hold();
    done = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(w_oe, 0);
    host.stop();
    done = 1'b0;
    repeat (8) @(negedge ref_clk);
    port_hold();
    host.strb_n[0] = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk(w_oe, 0);
    host.stop();
    $display("wait tests done");
    port_hold();
    host.rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(got, 9'h000);
    chk({w_oe, wm}, 9'h000);
    host.stop();
    host.rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    $display("reset test done");
    complete_run();
  end
endmodule // test_isa_slave_strobe_width_decode
bind isw_decode isw_decode_asserts chk_i (.ref_clk, .rst, .bus_addr,
  .mem_read_strobe_n, .lowmeg_read_strobe_n, .port_read_strobe_n,
  .bus_width_strap, .shared_mem_mode, .wide_mem_cycle_ack_o,
  .wide_mem_cycle_ack_oe, .wide_io_cycle_ack_o, .wide_io_cycle_ack_oe,
  .wait_insert_ready_oe, .mem_rd_sel, .prom_rd_sel, .port_rd_sel,
  .drive_all_lanes, .wide_mode);
